/* rtl/lks_pkg.sv */
// Constants and helpers shared by the LCD timing and keypad sweep block
package lks_pkg;
	localparam int PADDR_W        = 8;
	localparam int DATA_W         = 8;
	localparam int CLK_HZ         = 25_000_000;
	localparam int CLK_PERIOD_NS  = 40;
	localparam int BASE_HZ        = 32768;
	localparam int TICK_DIV       = CLK_HZ / BASE_HZ;
	localparam int COM_SLOT_TICKS = 4;
	localparam int SLOT_CYC       = 8;
	localparam int NUM_SEG        = 80;
	localparam int NUM_COM        = 24;
	localparam int NUM_KEYSEG     = 16;
	localparam int RAM_DEPTH      = 384;
	localparam int RAM_AW         = 9;

	localparam logic [PADDR_W-1:0] REG_CTRL     = 8'h00;
	localparam logic [PADDR_W-1:0] REG_DADDR_LO = 8'h04;
	localparam logic [PADDR_W-1:0] REG_DADDR_HI = 8'h08;
	localparam logic [PADDR_W-1:0] REG_DDATA    = 8'h0c;
	localparam logic [PADDR_W-1:0] REG_STRB_LO  = 8'h10;
	localparam logic [PADDR_W-1:0] REG_STRB_HI  = 8'h14;
	localparam logic [PADDR_W-1:0] REG_STATUS   = 8'h18;

	localparam int CB_CM    = 0;
	localparam int CB_OP    = 2;
	localparam int CB_KSCAN = 4;
	localparam int CB_KSTRB = 5;
	localparam int CB_KCHK  = 6;
	localparam int DADDR_MSB_BIT = 7;

	localparam logic [7:0]  CTRL_RST    = 8'h00;
	localparam logic [7:0]  CTRL_WMASK  = 8'h7f;
	localparam logic [7:0]  CTRL_RD_SET = 8'h80;
	localparam logic [1:0]  CM_16       = 2'h0;
	localparam logic [1:0]  CM_9        = 2'h1;
	localparam logic [1:0]  CM_8        = 2'h2;
	localparam logic [1:0]  CM_24       = 2'h3;
	localparam logic [1:0]  OP_DIS      = 2'h0;
	localparam logic [1:0]  OP_BLANK    = 2'h1;
	localparam logic [1:0]  OP_RSVD     = 2'h2;
	localparam logic [1:0]  OP_ON       = 2'h3;
	localparam logic [3:0]  KEY_IDLE    = 4'hf;
	localparam logic [15:0] STRB_RST    = 16'hffff;

	function automatic logic [4:0] ncom_f(input logic [1:0] mode);
		case (mode)
			CM_16:   ncom_f = 5'h10;
			CM_9:    ncom_f = 5'h09;
			CM_8:    ncom_f = 5'h08;
			default: ncom_f = 5'h18;
		endcase
	endfunction
endpackage

/* rtl/lks_disp_ram.sv */
// Display RAM: CPU port and refresh read port, both with registered read data
`timescale 1ns/1ps
module lks_disp_ram #(
	parameter int DEPTH = lks_pkg::RAM_DEPTH,
	parameter int AW    = lks_pkg::RAM_AW,
	parameter int DW    = lks_pkg::DATA_W
) (
	input  wire logic          clk,
	input  wire logic          ce,
	input  wire logic          a_we,
	input  wire logic [AW-1:0] a_addr,
	input  wire logic [DW-1:0] a_wdata,
	output logic      [DW-1:0] a_rdata,
	input  wire logic [AW-1:0] b_addr,
	output logic      [DW-1:0] b_rdata
);
	logic [DW-1:0] mem [DEPTH];

	if (DEPTH > (1 << AW)) begin : g_bad_depth
		$error("DEPTH does not fit the address width");
	end

	// Locations past DEPTH are empty: writes dropped, reads give zero
	always_ff @(posedge clk) begin
		if (ce) begin
			if (a_we && 32'(a_addr) < DEPTH)
				mem[a_addr] <= a_wdata;
			a_rdata <= (32'(a_addr) < DEPTH) ? mem[a_addr] : '0;
			b_rdata <= (32'(b_addr) < DEPTH) ? mem[b_addr] : '0;
		end
	end
endmodule // lks_disp_ram

/* rtl/lks_ctrl.sv */
// LCD common/segment timing, display RAM access and keypad strobe sweep
`timescale 1ns/1ps
// Operation
// - Mode codes 00,01,10: quarter bias, shared pins are segments 0 to 7.
// - Mode code 11: 24 commons, fifth bias, shared pins carry commons 16 to 23.
// - Operation field: 00 off, 01 blanking, 10 reserved, 11 display on.
// - All display timing comes from the 32.768kHz base tick.
// - Duty, segment and common counts follow from the mode field only.
// - Duty 8, 9, 16, 24 uses that many commons; the rest stay idle.
// - RAM bit one selects the segment in that common slot, zero deselects.
// - Byte bits 0 to 7 map to successive commons across the three banks.
// - Pixels live in display RAM, reached by address pair and data register.
// - Scan-enable bit inserts a pulse each frame; cleared, no pulse.
// - Strobe bit drives segments 8 to 23 low one at a time.
// - Key rows not all high during a slot latch zero for that segment.
// - The strobe bit clears itself after the sixteenth segment.
// - Key-check bit holds segments 8 to 23 low.
// - Strobe and key-check work in every display operation.
// - Results for segments 8-15 in the low register, 16-23 in the high.
// - Ninth address bit selects locations above FFh for commons 16 to 23.
// - Banks at 00h, 80h, 100h serve commons 0-7, 8-15, 16-23.
module lks_ctrl #(
	parameter int TICK_DIV       = lks_pkg::TICK_DIV,
	parameter int COM_SLOT_TICKS = lks_pkg::COM_SLOT_TICKS,
	parameter int SLOT_CYC       = lks_pkg::SLOT_CYC
) (
	input  wire logic                           ref_clk,
	input  wire logic                           rst,
	input  wire logic                           ce,
	input  wire logic                           psel,
	input  wire logic                           penable,
	input  wire logic                           pwrite,
	input  wire logic [lks_pkg::PADDR_W-1:0]    paddr,
	input  wire logic [31:0]                    pwdata,
	output logic      [31:0]                    prdata,
	output logic                                pready,
	output logic                                pslverr,
	input  wire logic [3:0]                     key_row_in,
	output logic      [lks_pkg::NUM_COM-1:0]    com_sel,
	output logic      [lks_pkg::NUM_SEG-1:0]    seg_sel,
	output logic      [lks_pkg::NUM_KEYSEG-1:0] key_seg_low,
	output logic                                shared_pin_com,
	output logic                                bias_fifth,
	output logic                                frame_ac,
	output logic                                keypad_sweep_pulse_enable_pulse
);
	import lks_pkg::*;

	typedef enum logic {KS_IDLE, KS_SWEEP} lks_ks_t;

	if (SLOT_CYC < 6 || SLOT_CYC > 255) begin : g_bad_slot
		$error("SLOT_CYC must lie in 6..255");
	end
	if (TICK_DIV > 1023 || COM_SLOT_TICKS > 255 || TICK_DIV * COM_SLOT_TICKS <= NUM_SEG + 2) begin : g_bad_tick
		$error("Common slot too short for a row refill");
	end

	logic [7:0]            ctrl_r, ctrl_nxt;
	logic [RAM_AW-1:0]     daddr_r, daddr_nxt;
	logic [15:0]           strb_res_r, strb_res_nxt;
	logic [15:0]           key_low_r, key_low_nxt;
	lks_ks_t               ks_state_r, ks_state_nxt;
	logic [3:0]            ks_idx_r, ks_idx_nxt;
	logic [7:0]            ks_slot_r, ks_slot_nxt;
	logic [3:0]            row_s1_r, row_s2_r, row_s3_r, row_f_r;
	logic [9:0]            tick_cnt_r, tick_cnt_nxt;
	logic [7:0]            cslot_r, cslot_nxt;
	logic [4:0]            com_r, com_nxt, com_up;
	logic [6:0]            fill_seg_r, fill_seg_nxt, fill_dseg_r, fill_dseg_nxt;
	logic                  fill_v_r, fill_v_nxt;
	logic [2:0]            fill_bit_r, fill_bit_nxt;
	logic [NUM_SEG-1:0]    row_buf_r, row_buf_nxt, seg_sel_r, seg_sel_nxt;
	logic [NUM_COM-1:0]    com_sel_r, com_sel_nxt;
	logic                  frame_ac_r, frame_ac_nxt, kpulse_r, kpulse_nxt;
	logic                  shared_r, shared_nxt, bias_r, bias_nxt;
	logic                  pready_r, pready_nxt, pslverr_r, pslverr_nxt;
	logic [31:0]           prdata_r, prdata_nxt;
	logic [DATA_W-1:0]     ram_a_rdata, ram_b_rdata;
	logic [RAM_AW-1:0]     ram_b_addr;
	logic                  acc, hit, wr, wr_ctl, ram_we, start, slot_end, ks_done;
	logic                  disp_on, tick, slot_chg;

	function automatic logic [4:0] next_com(input logic [4:0] c, input logic [1:0] mode);
		next_com = (c + 5'h01 >= ncom_f(mode)) ? 5'h00 : c + 5'h01;
	endfunction

	lks_disp_ram lks_disp_ram_inst (
		.clk     (ref_clk),
		.ce      (ce),
		.a_we    (ram_we),
		.a_addr  (daddr_r),
		.a_wdata (pwdata[DATA_W-1:0]),
		.a_rdata (ram_a_rdata),
		.b_addr  (ram_b_addr),
		.b_rdata (ram_b_rdata)
	);

	// Bus slave: one wait state on every access, writes land on the pready edge
	always_comb begin
		acc = psel && penable;
		case (paddr)
			REG_CTRL, REG_DADDR_LO, REG_DADDR_HI, REG_DDATA,
			REG_STRB_LO, REG_STRB_HI, REG_STATUS: hit = 1'b1;
			default: hit = 1'b0;
		endcase
		wr = acc && pready_r && pwrite && hit;
		wr_ctl = wr && paddr == REG_CTRL;
		ram_we = wr && paddr == REG_DDATA;
		pready_nxt = acc && !pready_r;
		pslverr_nxt = acc && !pready_r && !hit;
		prdata_nxt = 32'h0;
		if (acc && !pready_r && !pwrite) begin
			case (paddr)
				REG_CTRL:     prdata_nxt[7:0] = ctrl_r | CTRL_RD_SET;
				REG_DADDR_LO: prdata_nxt[7:0] = daddr_r[7:0];
				REG_DADDR_HI: prdata_nxt[DADDR_MSB_BIT] = daddr_r[8];
				REG_DDATA:    prdata_nxt[7:0] = ram_a_rdata;
				REG_STRB_LO:  prdata_nxt[7:0] = strb_res_r[7:0];
				REG_STRB_HI:  prdata_nxt[7:0] = strb_res_r[15:8];
				REG_STATUS:   prdata_nxt[12:0] = {com_r, 5'h00, ks_state_r == KS_SWEEP, shared_r, bias_r};
				default:      prdata_nxt = 32'h0;
			endcase
		end
		daddr_nxt = daddr_r;
		if (wr && paddr == REG_DADDR_LO)
			daddr_nxt[7:0] = pwdata[7:0];
		if (wr && paddr == REG_DADDR_HI)
			daddr_nxt[8] = pwdata[DADDR_MSB_BIT];
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			pready_r <= 1'b0;
			pslverr_r <= 1'b0;
			prdata_r <= 32'h0;
			daddr_r <= '0;
		end else if (ce) begin
			pready_r <= pready_nxt;
			pslverr_r <= pslverr_nxt;
			prdata_r <= prdata_nxt;
			daddr_r <= daddr_nxt;
		end
	end

	// Key rows come off pins: three stages, a change counts once stages two and three agree
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			row_s1_r <= KEY_IDLE;
			row_s2_r <= KEY_IDLE;
			row_s3_r <= KEY_IDLE;
			row_f_r <= KEY_IDLE;
		end else if (ce) begin
			row_s1_r <= key_row_in;
			row_s2_r <= row_s1_r;
			row_s3_r <= row_s2_r;
			if (row_s2_r == row_s3_r)
				row_f_r <= row_s3_r;
		end
	end

	// Control register and strobe sweep; neither looks at the display operation
	always_comb begin
		slot_end = ks_slot_r == 8'(SLOT_CYC - 1);
		ks_done = ks_state_r == KS_SWEEP && slot_end && ks_idx_r == 4'hf;
		// A new start written in the finishing cycle beats the self-clear
		start = wr_ctl && pwdata[CB_KSTRB] && (!ctrl_r[CB_KSTRB] || ks_done);
		ctrl_nxt = ctrl_r;
		if (wr_ctl)
			ctrl_nxt = pwdata[7:0] & CTRL_WMASK;
		if (ks_done && !start)
			ctrl_nxt[CB_KSTRB] = 1'b0;
		ks_state_nxt = ks_state_r;
		ks_idx_nxt = ks_idx_r;
		ks_slot_nxt = ks_slot_r;
		strb_res_nxt = strb_res_r;
		case (ks_state_r)
			KS_IDLE: ks_slot_nxt = 8'h00;
			KS_SWEEP: begin
				ks_slot_nxt = slot_end ? 8'h00 : ks_slot_r + 8'h01;
				if (slot_end) begin
					// Sampled late in the slot so the filtered rows have settled
					if (row_f_r != KEY_IDLE)
						strb_res_nxt[ks_idx_r] = 1'b0;
					ks_idx_nxt = ks_idx_r + 4'h1;
					if (ks_done)
						ks_state_nxt = KS_IDLE;
				end
				if (!ctrl_nxt[CB_KSTRB])
					ks_state_nxt = KS_IDLE;
			end
			default: ks_state_nxt = KS_IDLE;
		endcase
		if (start) begin
			ks_state_nxt = KS_SWEEP;
			ks_idx_nxt = 4'h0;
			ks_slot_nxt = 8'h00;
			strb_res_nxt = STRB_RST;
		end
		key_low_nxt = ctrl_nxt[CB_KCHK] ? 16'hffff : 16'h0000;
		if (ks_state_nxt == KS_SWEEP)
			key_low_nxt[ks_idx_nxt] = 1'b1;
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			ctrl_r <= CTRL_RST;
			ks_state_r <= KS_IDLE;
			ks_idx_r <= 4'h0;
			ks_slot_r <= 8'h00;
			strb_res_r <= STRB_RST;
			key_low_r <= 16'h0000;
		end else if (ce) begin
			ctrl_r <= ctrl_nxt;
			ks_state_r <= ks_state_nxt;
			ks_idx_r <= ks_idx_nxt;
			ks_slot_r <= ks_slot_nxt;
			strb_res_r <= strb_res_nxt;
			key_low_r <= key_low_nxt;
		end
	end

	// Common timing and row refill; each row is fetched during the slot before it shows
	always_comb begin
		disp_on = ctrl_r[CB_OP +: 2] == OP_ON || ctrl_r[CB_OP +: 2] == OP_BLANK;
		com_up = next_com(com_r, ctrl_r[CB_CM +: 2]);
		tick = tick_cnt_r == 10'(TICK_DIV - 1);
		slot_chg = disp_on && tick && cslot_r == 8'(COM_SLOT_TICKS - 1);
		tick_cnt_nxt = tick ? 10'h000 : tick_cnt_r + 10'h001;
		cslot_nxt = cslot_r;
		com_nxt = com_r;
		com_sel_nxt = com_sel_r;
		seg_sel_nxt = seg_sel_r;
		frame_ac_nxt = frame_ac_r;
		if (!disp_on) begin
			tick_cnt_nxt = 10'h000;
			cslot_nxt = 8'h00;
			com_nxt = 5'h00;
			com_sel_nxt = '0;
			frame_ac_nxt = 1'b0;
		end else begin
			if (tick)
				cslot_nxt = slot_chg ? 8'h00 : cslot_r + 8'h01;
			if (slot_chg) begin
				com_nxt = com_up;
				com_sel_nxt = 24'h000001 << com_up;
				seg_sel_nxt = row_buf_r;
				if (com_up == 5'h00)
					frame_ac_nxt = !frame_ac_r;
			end
		end
		// Forced every cycle, so a mode change mid-slot frees the shared pins at once
		if (ctrl_r[CB_CM +: 2] == CM_24)
			seg_sel_nxt[7:0] = 8'h00;
		if (ctrl_r[CB_OP +: 2] != OP_ON)
			seg_sel_nxt = '0;
		shared_nxt = ctrl_r[CB_CM +: 2] == CM_24;
		bias_nxt = ctrl_r[CB_CM +: 2] == CM_24;
		kpulse_nxt = ctrl_nxt[CB_KSCAN] && disp_on && (slot_chg ? com_up == 5'h00 : kpulse_r);
		fill_v_nxt = fill_seg_r < 7'(NUM_SEG);
		fill_seg_nxt = slot_chg ? 7'h00 : (fill_v_nxt ? fill_seg_r + 7'h01 : fill_seg_r);
		fill_dseg_nxt = fill_seg_r;
		fill_bit_nxt = com_up[2:0];
		ram_b_addr = {com_up[4:3], fill_seg_r};
		row_buf_nxt = row_buf_r;
		if (fill_v_r)
			row_buf_nxt[fill_dseg_r] = ram_b_rdata[fill_bit_r];
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			tick_cnt_r <= 10'h000;
			cslot_r <= 8'h00;
			com_r <= 5'h00;
			com_sel_r <= '0;
			seg_sel_r <= '0;
			frame_ac_r <= 1'b0;
			kpulse_r <= 1'b0;
			shared_r <= 1'b0;
			bias_r <= 1'b0;
			fill_seg_r <= 7'h00;
			fill_dseg_r <= 7'h00;
			fill_v_r <= 1'b0;
			fill_bit_r <= 3'h0;
			row_buf_r <= '0;
		end else if (ce) begin
			tick_cnt_r <= tick_cnt_nxt;
			cslot_r <= cslot_nxt;
			com_r <= com_nxt;
			com_sel_r <= com_sel_nxt;
			seg_sel_r <= seg_sel_nxt;
			frame_ac_r <= frame_ac_nxt;
			kpulse_r <= kpulse_nxt;
			shared_r <= shared_nxt;
			bias_r <= bias_nxt;
			fill_seg_r <= fill_seg_nxt;
			fill_dseg_r <= fill_dseg_nxt;
			fill_v_r <= fill_v_nxt;
			fill_bit_r <= fill_bit_nxt;
			row_buf_r <= row_buf_nxt;
		end
	end

	assign prdata = prdata_r;
	assign pready = pready_r;
	assign pslverr = pslverr_r;
	assign com_sel = com_sel_r;
	assign seg_sel = seg_sel_r;
	assign key_seg_low = key_low_r;
	assign shared_pin_com = shared_r;
	assign bias_fifth = bias_r;
	assign frame_ac = frame_ac_r;
	assign keypad_sweep_pulse_enable_pulse = kpulse_r;

	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst || !ce);

	AST_QUARTER_BIAS: assert property (ctrl_r[CB_CM +: 2] != CM_24 |=> !bias_fifth && !shared_pin_com)
		else $error("Quarter bias modes must keep shared pins as segments");
	AST_FIFTH_BIAS: assert property (ctrl_r[CB_CM +: 2] == CM_24 |=> bias_fifth && shared_pin_com && seg_sel[7:0] == 8'h00)
		else $error("24-common mode must move shared pins to commons");
	AST_DISP_OFF: assert property (!disp_on |=> com_sel == '0 && seg_sel == '0)
		else $error("Disabled display still drives commons or segments");
	AST_BLANK_SEG: assert property (ctrl_r[CB_OP +: 2] == OP_BLANK |=> seg_sel == '0)
		else $error("Blanking left a segment selected");
	AST_UNUSED_COM: assert property (slot_chg |=> (com_sel >> ncom_f($past(ctrl_r[CB_CM +: 2]))) == '0 && $onehot(com_sel))
		else $error("Common outside the duty was driven");
	AST_SCAN_OFF: assert property (!ctrl_r[CB_KSCAN] |-> !keypad_sweep_pulse_enable_pulse)
		else $error("Key-scan pulse with scan disabled");
	AST_KEYPAD_HOLD_LOW_ENABLE: assert property (ctrl_r[CB_KCHK] |-> key_seg_low == 16'hffff)
		else $error("Key check did not hold segments low");
	AST_SWEEP_START: assert property (start && !ctrl_nxt[CB_KCHK] |=> key_seg_low == 16'h0001 && strb_res_r == STRB_RST)
		else $error("Sweep did not start at segment 8 with results preset");
	AST_SWEEP_STEP: assert property (ks_state_r == KS_SWEEP && slot_end && ks_idx_r != 4'hf && !wr_ctl
		&& !ctrl_r[CB_KCHK] |=> key_seg_low == ($past(key_seg_low) << 1))
		else $error("Strobe did not move to the next segment");
	AST_LATCH: assert property (ks_state_r == KS_SWEEP && slot_end && row_f_r != KEY_IDLE && !start
		|=> !strb_res_r[$past(ks_idx_r)])
		else $error("Pressed key not latched as zero");
	AST_SELF_CLEAR: assert property (ks_done && !start |=> !ctrl_r[CB_KSTRB] && ks_state_r == KS_IDLE)
		else $error("Strobe bit not cleared after the sweep");

	COV_SWEEP_DONE: cover property (ks_done);
	COV_KEY_FOUND: cover property (ks_state_r == KS_SWEEP && slot_end && row_f_r != KEY_IDLE);
	COV_COM24_SLOT: cover property (slot_chg && ctrl_r[CB_CM +: 2] == CM_24 && com_up == 5'h17);
	COV_BLANK_RUN: cover property (slot_chg && ctrl_r[CB_OP +: 2] == OP_BLANK);
endmodule // lks_ctrl

/* tb/lks_key_matrix.sv */
// Key matrix model: a pressed key pulls its row low while its strobe segment is low
`timescale 1ns/1ps
module lks_key_matrix (
	input  wire logic [15:0] key_seg_low,
	input  wire logic [15:0] press_mask,
	input  wire logic [3:0]  press_row,
	output logic      [3:0]  key_row_in
);
	// Rows have pull-ups, so with no closed switch on a low segment they read high
	always_comb begin
		key_row_in = 4'hf;
		if ((key_seg_low & press_mask) != 16'h0000) begin
			key_row_in = ~press_row;
		end
	end
endmodule // lks_key_matrix

/* tb/lcd_keypad_scan_controller_bench.sv */
// Register-level bench for the LCD timing and keypad sweep block
`timescale 1ns/1ps
module lcd_keypad_scan_controller_bench;
	import lks_pkg::*;
	// Short base tick keeps a 24-common frame near 3000 cycles
	localparam int TDIV = 32;
	localparam int CST  = 4;
	localparam int SCYC = 8;
	localparam int SLOT = TDIV * CST;
	logic        ref_clk = 1'b0;
	logic        rst;
	logic        ce;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [7:0]  paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic [3:0]  key_row_in;
	logic [23:0] com_sel;
	logic [79:0] seg_sel;
	logic [15:0] key_seg_low;
	logic        shared_pin_com;
	logic        bias_fifth;
	logic        frame_ac;
	logic        keypad_sweep_pulse_enable_pulse;
	logic [15:0] press_mask;
	logic [3:0]  press_row;
	logic [31:0] rd;
	logic        err;
	logic [23:0] cm_or;
	logic        s5;
	logic        kp;
	logic [1:0]  fa;
	int          ncom [4] = '{16, 9, 8, 24};
	int          num_errors = 0;
	int          cmp_count = 0;

	always #20 ref_clk = ~ref_clk;

	lks_ctrl #(.TICK_DIV(TDIV), .COM_SLOT_TICKS(CST), .SLOT_CYC(SCYC)) lks_ctrl_inst (
		.ref_clk(ref_clk), .rst(rst), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.key_row_in(key_row_in), .com_sel(com_sel), .seg_sel(seg_sel), .key_seg_low(key_seg_low),
		.shared_pin_com(shared_pin_com), .bias_fifth(bias_fifth), .frame_ac(frame_ac),
		.keypad_sweep_pulse_enable_pulse(keypad_sweep_pulse_enable_pulse)
	);

	lks_key_matrix lks_key_matrix_inst (
		.key_seg_low(key_seg_low), .press_mask(press_mask), .press_row(press_row), .key_row_in(key_row_in)
	);

	task automatic summarize();
		$display("comparisons %0d mismatches %0d", cmp_count, num_errors);
		if (num_errors == 0 && cmp_count > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			num_errors++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
		end
	endtask

	// Request held until pready is sampled high; data and error taken at that edge
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge ref_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1'b1;
		do begin
			@(posedge ref_clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (pready !== 1'b1) begin
			num_errors++;
			summarize();
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		apb(1'b1, a, {24'h0, d});
	endtask

	task automatic rdchk(input string name, input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		check(name, rd, exp);
	endtask

	task automatic observe(input int cyc);
		cm_or = '0;
		s5 = 1'b0;
		kp = 1'b0;
		fa = 2'b00;
		repeat (cyc) begin
			@(posedge ref_clk);
			#1;
			cm_or = cm_or | com_sel;
			fa = fa | (2'b01 << frame_ac);
			s5 = s5 | seg_sel[5];
			kp = kp | keypad_sweep_pulse_enable_pulse;
		end
	endtask

	// Index 24 waits for the scan pulse; samples land mid-slot, clear of refill lag
	task automatic wait_com(input int idx);
		int n;
		n = 0;
		do begin
			@(posedge ref_clk);
			#1;
			n++;
		end while ((idx < 24 ? com_sel[idx] : keypad_sweep_pulse_enable_pulse) !== 1'b1 && n < 8000);
		if (n >= 8000) begin
			num_errors++;
			summarize();
		end
		repeat (SLOT / 2) @(posedge ref_clk);
		#1;
	endtask

	initial begin
		rst = 1'b1;
		ce = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		press_mask = 16'h0000;
		press_row = 4'h0;
		repeat (8) @(posedge ref_clk);
		rst <= 1'b0;
		rdchk("ctrl_reset", REG_CTRL, {24'h0, CTRL_RST | CTRL_RD_SET});
		apb(1'b0, 8'h1c, 32'h0);
		check("unmapped_err", {31'h0, err}, 32'h1);
		check("unmapped_data", rd, 32'h0);
		wr(REG_DADDR_LO, 8'h05);
		wr(REG_DADDR_HI, 8'h00);
		wr(REG_DDATA, 8'hff);
		rdchk("ram_bank0", REG_DDATA, 32'hff);
		for (int i = 0; i < 4; i++) begin
			wr(REG_CTRL, {4'h0, OP_ON, 2'(i)});
			apb(1'b0, REG_STATUS, 32'h0);
			check("status_mode", {30'h0, rd[1:0]}, (i == 3) ? 32'h3 : 32'h0);
			check("bias_pin", {31'h0, bias_fifth}, (i == 3) ? 32'h1 : 32'h0);
			check("shared_pin", {31'h0, shared_pin_com}, (i == 3) ? 32'h1 : 32'h0);
			// The common left over from the previous mode stands until its slot ends
			repeat (SLOT) @(posedge ref_clk);
			observe((2 * ncom[i] + 1) * SLOT);
			check("com_span", {8'h0, cm_or}, {8'h0, (24'h1 << ncom[i]) - 24'h1});
			check("frame_toggle", {30'h0, fa}, 32'h3);
			check("seg5_on", {31'h0, s5}, (i == 3) ? 32'h0 : 32'h1);
		end
		for (int op = 0; op < 4; op++) begin
			wr(REG_CTRL, {4'h0, 2'(op), CM_8});
			observe(17 * SLOT);
			check("op_com", {8'h0, cm_or}, (op == 1 || op == 3) ? 32'hff : 32'h0);
			check("op_seg", {31'h0, s5}, (op == 3) ? 32'h1 : 32'h0);
			check("op_frame", {30'h0, fa}, (op == 1 || op == 3) ? 32'h3 : 32'h1);
		end
		wr(REG_DADDR_HI, 8'h01 << DADDR_MSB_BIT);
		wr(REG_DADDR_LO, 8'h0a);
		wr(REG_DDATA, 8'h02);
		rdchk("ram_bank2", REG_DDATA, 32'h02);
		wr(REG_CTRL, {4'h0, OP_ON, CM_24});
		wait_com(17);
		check("com17_seg10", {31'h0, seg_sel[10]}, 32'h1);
		wait_com(16);
		check("com16_seg10", {31'h0, seg_sel[10]}, 32'h0);
		wr(REG_CTRL, 8'h1e);
		wait_com(24);
		check("scan_at_com0", {8'h0, com_sel}, 32'h1);
		wr(REG_CTRL, 8'h0e);
		observe(17 * SLOT);
		check("scan_off", {31'h0, kp}, 32'h0);
		press_mask <= 16'h1008;
		press_row <= 4'h2;
		wr(REG_CTRL, 8'h22);
		@(posedge ref_clk);
		#1;
		check("strobe_first", {16'h0, key_seg_low}, 32'h0001);
		repeat (SCYC) @(posedge ref_clk);
		#1;
		check("strobe_second", {16'h0, key_seg_low}, 32'h0002);
		repeat (16 * SCYC) @(posedge ref_clk);
		rdchk("strobe_clear", REG_CTRL, 32'h82);
		rdchk("result_low", REG_STRB_LO, 32'hf7);
		rdchk("result_high", REG_STRB_HI, 32'hef);
		press_mask <= 16'h0000;
		wr(REG_CTRL, 8'h22);
		repeat (17 * SCYC) @(posedge ref_clk);
		rdchk("preset_low", REG_STRB_LO, 32'hff);
		rdchk("preset_high", REG_STRB_HI, 32'hff);
		wr(REG_CTRL, 8'h42);
		@(posedge ref_clk);
		#1;
		check("keypad_hold_low_enable_on", {16'h0, key_seg_low}, 32'hffff);
		wr(REG_CTRL, 8'h02);
		@(posedge ref_clk);
		#1;
		check("keypad_hold_low_enable_off", {16'h0, key_seg_low}, 32'h0000);
		// A low clock enable must hold the sweep on its first segment
		wr(REG_CTRL, 8'h22);
		ce <= 1'b0;
		repeat (3 * SCYC) @(posedge ref_clk);
		#1;
		check("ce_freeze", {16'h0, key_seg_low}, 32'h0001);
		ce <= 1'b1;
		repeat (SCYC) @(posedge ref_clk);
		#1;
		check("ce_resume", {16'h0, key_seg_low}, 32'h0002);
		summarize();
	end
endmodule // lcd_keypad_scan_controller_bench
